// ==== hdl/regset_pkg.sv ====
// shared constants, types and carriers for the core register set
package regset_pkg;

  // register file shape
  localparam int XLEN = 32;
  localparam int NGPR = 16;
  localparam logic [3:0] IDX_GPR = 4'h0;
  localparam logic [3:0] STK_GPR = 4'hF;

  // status word layout: interrupt mask field and writable bits
  localparam int IMASK_LSB = 4;
  localparam int IMASK_W = 4;
  localparam logic [31:0] SW_WRITABLE = 32'h000003F3;
  localparam logic [31:0] SW_RESET = 32'h000000F0;

  // reset values of the control registers
  localparam logic [31:0] VBASE_RESET = 32'h00000000;
  localparam logic [31:0] REG_CLEAR = 32'h00000000;

  // vector table slots read at reset, relative to the vector base
  localparam logic [31:0] VEC_PC_OFS = 32'h00000000;
  localparam logic [31:0] VEC_SP_OFS = 32'h00000004;

  // stack step for one longword
  localparam logic [31:0] STACK_STEP = 32'h00000004;

  // chip-select area decode on the upper address bits
  localparam int AREA_SEL_LSB = 25;
  localparam int AREA_SEL_W = 3;
  localparam logic [2:0] AREA_TWO = 3'h2;

  // byte enable patterns, bit 3 is the lane of offset 0
  localparam logic [3:0] BE_ALL = 4'hF;
  localparam logic [3:0] BE_HI_HALF = 4'hC;
  localparam logic [3:0] BE_LO_HALF = 4'h3;
  localparam logic [3:0] BE_LANE0 = 4'h8;

  typedef enum logic [1:0] {sz_byte, sz_word, sz_long} acc_size_t;

  typedef enum logic [2:0] {spr_status, spr_gbase, spr_vbase, spr_mac_high, spr_mac_low,
    spr_link, spr_pc} spr_sel_t;

  typedef enum logic [1:0] {st_boot_pc, st_boot_sp, st_idle, st_bus} seq_state_t;

  typedef enum logic [1:0] {tgt_pc, tgt_sp, tgt_exe} bus_tgt_t;

  // general register write from the execution logic
  typedef struct packed {
    logic en;
    logic to_index;
    logic [3:0] idx;
    logic [31:0] data;
  } gpr_wr_t;

  // control or system register write
  typedef struct packed {
    logic en;
    spr_sel_t sel;
    logic [31:0] data;
  } spr_wr_t;

  // memory access request from the execution logic
  typedef struct packed {
    logic valid;
    logic write;
    logic stack_acc;
    acc_size_t size;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] dest;
  } mem_req_t;

endpackage

// ==== hdl/mem_access.sv ====
// operand formatting: alignment check, byte order and sign extension
`timescale 1ns/10ps
module mem_access
  import regset_pkg::*;
(
  input mem_req_t req,
  input wire logic [31:0] rdata_bus,
  output logic misalign,
  output logic area_two,
  output logic [31:0] wdata_lanes,
  output logic [3:0] byte_en,
  output logic [31:0] load_value
);

  // byte at address offset i sits in lane 3-i on the bus
  function automatic logic [7:0] get_byte(input logic [31:0] w, input logic [1:0] i);
    get_byte = w[(3 - i) * 8 +: 8];
  endfunction

  function automatic logic [31:0] swap32(input logic [31:0] w);
    swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  wire logic [1:0] ofs = req.addr[1:0];
  wire logic [1:0] ofs_pair = {ofs[1], 1'b1};
  wire logic is_word = (req.size == sz_word);
  wire logic is_long = (req.size == sz_long);
  wire logic [7:0] b_lo = get_byte(rdata_bus, ofs);
  wire logic [7:0] b_hi = get_byte(rdata_bus, ofs_pair);
  wire logic [7:0] wb0 = req.wdata[7:0];
  wire logic [7:0] wb1 = req.wdata[15:8];

  // bytes anywhere, words on 2n, longwords on 4n
  wire logic size_bad = (is_word && ofs[0]) || (is_long && (ofs != 2'b00));
  // the stack only ever holds aligned longwords
  wire logic stack_bad = req.stack_acc && (!is_long || (ofs != 2'b00));
  assign misalign = size_bad || stack_bad;

  // area two swaps the byte order, every other area stays big-endian
  assign area_two = (req.addr[AREA_SEL_LSB +: AREA_SEL_W] == AREA_TWO);

  // write lanes: narrow data is replicated so the byte enables pick it
  assign wdata_lanes = is_long ? (area_two ? swap32(req.wdata) : req.wdata) :
    is_word ? (area_two ? {wb0, wb1, wb0, wb1} : {wb1, wb0, wb1, wb0}) :
    {wb0, wb0, wb0, wb0};
  assign byte_en = is_long ? BE_ALL : is_word ? (ofs[1] ? BE_LO_HALF : BE_HI_HALF) :
    (BE_LANE0 >> ofs);

  // loads: pick the lanes, order them, then sign-extend to a longword
  wire logic [15:0] word_val = area_two ? {b_hi, b_lo} : {b_lo, b_hi};
  wire logic [31:0] long_val = area_two ? swap32(rdata_bus) : rdata_bus;
  assign load_value = is_long ? long_val :
    is_word ? {{16{word_val[15]}}, word_val} :
    {{24{b_lo[7]}}, b_lo};

endmodule

// ==== hdl/cpu_regset.sv ====
// core architectural register set with reset vector fetch and load path
`timescale 1ns/10ps
module cpu_regset
  import regset_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [3:0] rd_a_idx,
  input wire logic [3:0] rd_b_idx,
  output logic [31:0] rd_a_data,
  output logic [31:0] rd_b_data,
  output logic [31:0] index_data,
  output logic [31:0] stack_pointer,
  input gpr_wr_t gpr_wr,
  input spr_wr_t spr_wr,
  input spr_sel_t spr_rd_sel,
  output logic [31:0] spr_rd_data,
  input wire logic mac_wr_en,
  input wire logic [63:0] mac_result,
  input wire logic link_wr_en,
  input wire logic [31:0] link_addr,
  input wire logic pc_load,
  input wire logic [31:0] pc_next,
  input wire logic sp_push,
  input wire logic sp_pop,
  input wire logic [31:0] gbase_disp,
  input wire logic [7:0] vec_num,
  output logic [31:0] index_addr,
  output logic [31:0] gbase_index_addr,
  output logic [31:0] gbase_disp_addr,
  output logic [31:0] vector_addr,
  output logic [31:0] status_word,
  output logic [31:0] global_base,
  output logic [31:0] vector_base,
  output logic [31:0] mac_high,
  output logic [31:0] mac_low,
  output logic [31:0] return_link,
  output logic [31:0] program_counter,
  output logic [3:0] interrupt_mask,
  output logic core_ready,
  input mem_req_t exe_req,
  output logic exe_ready,
  output logic load_done,
  output logic [31:0] load_data,
  output logic addr_error,
  output logic bus_req,
  output logic bus_write,
  output logic [31:0] bus_addr,
  output logic [31:0] bus_wdata,
  output logic [3:0] bus_be,
  output logic bus_area_two,
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata
);

  // register storage
  logic [31:0] gpr_r [0:NGPR-1];
  logic [31:0] status_r, gbase_r, vbase_r, mac_high_r, mac_low_r, link_r, pc_r;

  // access sequencer
  seq_state_t state_r, state_nxt;
  bus_tgt_t tgt_r;
  mem_req_t cur_r;
  logic bus_req_r, bus_write_r, bus_area_r, load_done_r, addr_err_r;
  logic [31:0] bus_addr_r, bus_wdata_r, load_data_r;
  logic [3:0] bus_be_r;

  // formatter wires
  mem_req_t acc_req, boot_req;
  logic acc_misalign, acc_area_two;
  logic [31:0] acc_wdata, acc_load;
  logic [3:0] acc_be;

  // read ports and the effective addresses built from the dedicated registers
  assign rd_a_data = gpr_r[rd_a_idx];
  assign rd_b_data = gpr_r[rd_b_idx];
  assign index_data = gpr_r[IDX_GPR];
  assign stack_pointer = gpr_r[STK_GPR];
  assign index_addr = rd_a_data + index_data;
  assign gbase_index_addr = gbase_r + index_data;
  assign gbase_disp_addr = gbase_r + gbase_disp;
  assign vector_addr = vbase_r + {22'h0, vec_num, 2'h0};

  // register views toward execution and exception logic
  assign status_word = status_r;
  assign global_base = gbase_r;
  assign vector_base = vbase_r;
  assign mac_high = mac_high_r;
  assign mac_low = mac_low_r;
  assign return_link = link_r;
  assign program_counter = pc_r;
  assign interrupt_mask = status_r[IMASK_LSB +: IMASK_W];

  // control and system register read select
  assign spr_rd_data = (spr_rd_sel == spr_status) ? status_r :
    (spr_rd_sel == spr_gbase) ? gbase_r :
    (spr_rd_sel == spr_vbase) ? vbase_r :
    (spr_rd_sel == spr_mac_high) ? mac_high_r :
    (spr_rd_sel == spr_mac_low) ? mac_low_r :
    (spr_rd_sel == spr_link) ? link_r : pc_r;

  // decoded write strobes
  wire logic wr_status = spr_wr.en && (spr_wr.sel == spr_status);
  wire logic wr_gbase = spr_wr.en && (spr_wr.sel == spr_gbase);
  wire logic wr_vbase = spr_wr.en && (spr_wr.sel == spr_vbase);
  wire logic wr_mac_high = spr_wr.en && (spr_wr.sel == spr_mac_high);
  wire logic wr_mac_low = spr_wr.en && (spr_wr.sel == spr_mac_low);
  wire logic wr_link = spr_wr.en && (spr_wr.sel == spr_link);
  wire logic wr_pc = spr_wr.en && (spr_wr.sel == spr_pc);

  // boot fetches read the vector table through the normal bus path
  assign boot_req = '{valid: 1'b1, write: 1'b0, stack_acc: 1'b0, size: sz_long,
    addr: vbase_r + ((state_r == st_boot_sp) ? VEC_SP_OFS : VEC_PC_OFS),
    wdata: REG_CLEAR, dest: STK_GPR};

  // while a cycle runs the formatter sees the latched request
  assign acc_req = (state_r == st_bus) ? cur_r :
    (state_r == st_idle) ? exe_req : boot_req;

  mem_access u_fmt (
    .req(acc_req),
    .rdata_bus(bus_rdata),
    .misalign(acc_misalign),
    .area_two(acc_area_two),
    .wdata_lanes(acc_wdata),
    .byte_en(acc_be),
    .load_value(acc_load)
  );

  // handshake terms
  wire logic in_idle = (state_r == st_idle);
  wire logic in_boot = (state_r == st_boot_pc) || (state_r == st_boot_sp);
  wire logic take_exe = in_idle && exe_req.valid;
  wire logic launch_ok = (take_exe && !acc_misalign) || in_boot;
  wire logic reject = take_exe && acc_misalign;
  wire logic done = (state_r == st_bus) && bus_ack;
  wire logic load_wr = done && (tgt_r == tgt_exe) && !cur_r.write;
  wire logic boot_pc_wr = done && (tgt_r == tgt_pc);
  wire logic boot_sp_wr = done && (tgt_r == tgt_sp);
  assign exe_ready = in_idle;
  assign core_ready = in_idle || ((state_r == st_bus) && (tgt_r == tgt_exe));

  // stack pointer updates: vector value, push predecrement, pop increment
  wire logic sp_wr = boot_sp_wr || sp_push || sp_pop;
  wire logic [31:0] sp_nxt = boot_sp_wr ? acc_load :
    sp_push ? (stack_pointer - STACK_STEP) : (stack_pointer + STACK_STEP);
  wire logic [3:0] gpr_wr_idx = gpr_wr.to_index ? IDX_GPR : gpr_wr.idx;

  // sequencer: fetch pc, fetch sp, then serve execution requests
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      st_boot_pc, st_boot_sp: state_nxt = st_bus;
      st_idle:
        if (take_exe && !acc_misalign)
          state_nxt = st_bus;
      st_bus:
      begin
        if (bus_ack)
        begin
          if (tgt_r == tgt_pc)
            state_nxt = st_boot_sp;
          else
            state_nxt = st_idle;
        end
      end
      default: state_nxt = st_idle;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      state_r <= st_boot_pc;
    else
      state_r <= state_nxt;
  end

  // latch request and target when a cycle is launched
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cur_r <= '0;
      tgt_r <= tgt_pc;
    end
    else if (launch_ok)
    begin
      cur_r <= acc_req;
      tgt_r <= (state_r == st_boot_pc) ? tgt_pc : (state_r == st_boot_sp) ? tgt_sp : tgt_exe;
    end
  end

  // bus outputs held from launch until the acknowledge edge
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      bus_req_r <= 1'b0;
      bus_write_r <= 1'b0;
      bus_addr_r <= REG_CLEAR;
      bus_wdata_r <= REG_CLEAR;
      bus_be_r <= 4'h0;
      bus_area_r <= 1'b0;
    end
    else if (launch_ok)
    begin
      bus_req_r <= 1'b1;
      bus_write_r <= acc_req.write;
      bus_addr_r <= acc_req.addr;
      bus_wdata_r <= acc_wdata;
      bus_be_r <= acc_be;
      bus_area_r <= acc_area_two;
    end
    else if (done)
      bus_req_r <= 1'b0;
  end

  // one-cycle completion and error pulses; error cycles never reach the bus
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      load_done_r <= 1'b0;
      load_data_r <= REG_CLEAR;
      addr_err_r <= 1'b0;
    end
    else
    begin
      load_done_r <= done && (tgt_r == tgt_exe);
      addr_err_r <= reject;
      if (load_wr)
        load_data_r <= acc_load;
    end
  end

  assign bus_req = bus_req_r;
  assign bus_write = bus_write_r;
  assign bus_addr = bus_addr_r;
  assign bus_wdata = bus_wdata_r;
  assign bus_be = bus_be_r;
  assign bus_area_two = bus_area_r;
  assign load_done = load_done_r;
  assign load_data = load_data_r;
  assign addr_error = addr_err_r;

  // general registers; later writes win, the stack pointer port last
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NGPR; i++)
        gpr_r[i] <= REG_CLEAR;
    end
    else
    begin
      if (gpr_wr.en)
        gpr_r[gpr_wr_idx] <= gpr_wr.data;
      if (load_wr)
        gpr_r[cur_r.dest] <= acc_load;
      if (sp_wr)
        gpr_r[STK_GPR] <= sp_nxt;
    end
  end

  // control registers; undefined-at-reset bits are cleared anyway
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      status_r <= SW_RESET;
      gbase_r <= REG_CLEAR;
      vbase_r <= VBASE_RESET;
    end
    else
    begin
      if (wr_status)
        status_r <= spr_wr.data & SW_WRITABLE;
      if (wr_gbase)
        gbase_r <= spr_wr.data;
      if (wr_vbase)
        vbase_r <= spr_wr.data;
    end
  end

  // system registers; dedicated ports beat the generic write
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      mac_high_r <= REG_CLEAR;
      mac_low_r <= REG_CLEAR;
      link_r <= REG_CLEAR;
      pc_r <= REG_CLEAR;
    end
    else
    begin
      if (mac_wr_en)
      begin
        mac_high_r <= mac_result[63:32];
        mac_low_r <= mac_result[31:0];
      end
      else if (wr_mac_high)
        mac_high_r <= spr_wr.data;
      else if (wr_mac_low)
        mac_low_r <= spr_wr.data;
      if (link_wr_en)
        link_r <= link_addr;
      else if (wr_link)
        link_r <= spr_wr.data;
      if (boot_pc_wr)
        pc_r <= acc_load;
      else if (pc_load)
        pc_r <= pc_next;
      else if (wr_pc)
        pc_r <= spr_wr.data;
    end
  end

endmodule

// ==== test/regset_checker.sv ====
// concurrent checks on the register set ports
`timescale 1ns/10ps
module regset_checker
  import regset_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [31:0] rd_a_data,
  input wire logic [31:0] index_data,
  input wire logic [31:0] index_addr,
  input wire logic [31:0] stack_pointer,
  input wire logic sp_push,
  input wire logic [31:0] gbase_disp,
  input wire logic [31:0] gbase_disp_addr,
  input wire logic [31:0] global_base,
  input wire logic [31:0] status_word,
  input wire logic [31:0] vector_base,
  input wire logic [31:0] mac_high,
  input wire logic [31:0] mac_low,
  input wire logic mac_wr_en,
  input wire logic [63:0] mac_result,
  input wire logic pc_load,
  input wire logic [31:0] pc_next,
  input wire logic [31:0] program_counter,
  input wire logic core_ready,
  input mem_req_t exe_req,
  input wire logic exe_ready,
  input wire logic addr_error,
  input wire logic bus_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // request decode; stack places are stricter than plain ones
  wire logic taken = exe_ready && exe_req.valid;
  wire logic bad_align = (exe_req.size == sz_word && exe_req.addr[0])
    || (exe_req.size == sz_long && exe_req.addr[1:0] != 2'h0);
  wire logic bad_stk = exe_req.stack_acc && (exe_req.size != sz_long || exe_req.addr[1:0] != 2'h0);
  a_reset_values: assert property ($rose(nrst) |-> status_word == SW_RESET && vector_base == 32'h0)
    else $error("reset value of status or vector base wrong");
  a_reserved_zero: assert property ((status_word & ~SW_WRITABLE) == 32'h0)
    else $error("reserved status bit set");
  a_index_sum: assert property (index_addr == rd_a_data + index_data)
    else $error("indexed address wrong");
  a_push_step: assert property (sp_push && core_ready |=> stack_pointer == $past(stack_pointer) - 32'h4)
    else $error("stack push step wrong");
  a_gbase_disp: assert property (gbase_disp_addr == global_base + gbase_disp)
    else $error("global base address wrong");
  a_mac_pair: assert property (mac_wr_en |=> {mac_high, mac_low} == $past(mac_result))
    else $error("mac pair not loaded");
  a_pc_load: assert property (pc_load && core_ready |=> program_counter == $past(pc_next))
    else $error("program counter not loaded");
  a_misalign_err: assert property (taken && bad_align |=> addr_error && !bus_req)
    else $error("misaligned access not refused");
  a_aligned_cycle: assert property (taken && !bad_align && !bad_stk |=> bus_req && !addr_error)
    else $error("aligned access not started");
  a_stack_long: assert property (taken && bad_stk |=> addr_error)
    else $error("bad stack access not refused");
endmodule

// ==== test/bus_mem_model.sv ====
// memory partner answering the core bus after a set wait
`timescale 1ns/10ps
module bus_mem_model
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [1:0] wait_n,
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic [3:0] bus_be,
  output logic bus_ack,
  output logic [31:0] bus_rdata
);
  logic [31:0] mem_r [16];
  logic [1:0] cnt_r;
  // vector table: pc slot then sp slot
  initial
  begin
    mem_r = '{default: 32'h0};
    mem_r[0] = 32'h00000400;
    mem_r[1] = 32'h0000FFF0;
  end
  // answer after wait_n cycles; idle data keeps changing so stale values never match
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      bus_ack <= 1'b0;
      cnt_r <= 2'h0;
      bus_rdata <= 32'h0;
    end
    else if (bus_ack)
    begin
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata;
    end
    else if (bus_req && cnt_r != wait_n)
      cnt_r <= cnt_r + 2'h1;
    else if (bus_req)
    begin
      cnt_r <= 2'h0;
      bus_ack <= 1'b1;
      bus_rdata <= mem_r[bus_addr[5:2]];
      // lane bit 3 is offset 0, bits 31:24
      for (int k = 0; k < 4; k++)
        if (bus_write && bus_be[k])
          mem_r[bus_addr[5:2]][k*8 +: 8] <= bus_wdata[k*8 +: 8];
    end
    else
      bus_rdata <= bus_rdata ^ 32'hA5A5A5A5;
  end
endmodule

// ==== test/cpu_regset_bench.sv ====
// self-checking bench for the core register set
`timescale 1ns/10ps
module cpu_regset_bench;
  import regset_pkg::*;
  logic clk_sys, nrst, mac_wr_en, link_wr_en, pc_load, sp_push, sp_pop, core_ready, exe_ready;
  logic load_done, addr_error, bus_req, bus_write, bus_area_two, bus_ack, got_err;
  logic [3:0] rd_a_idx, rd_b_idx, interrupt_mask, bus_be;
  logic [31:0] rd_a_data, rd_b_data, index_data, stack_pointer, spr_rd_data, index_addr;
  logic [31:0] gbase_index_addr, gbase_disp_addr, vector_addr, status_word, global_base;
  logic [31:0] vector_base, mac_high, mac_low, return_link, program_counter, load_data;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, pc_next, link_addr, gbase_disp, seen_wd;
  logic [63:0] mac_result;
  logic [7:0] vec_num;
  logic [1:0] wait_n;
  gpr_wr_t gpr_wr;
  spr_wr_t spr_wr;
  spr_sel_t spr_rd_sel;
  mem_req_t exe_req;
  int mismatches, n_checks;
  cpu_regset i_dut (.*);
  bus_mem_model i_mem (.*);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one-cycle strobes; trailing edge keeps drivers from colliding
  task automatic wr_gpr(input logic [3:0] idx, input logic [31:0] d, input logic to_idx);
    gpr_wr = '{en: 1'b1, to_index: to_idx, idx: idx, data: d};
    @(negedge clk_sys);
    gpr_wr.en = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic wr_spr(input spr_sel_t sel, input logic [31:0] d);
    spr_wr = '{en: 1'b1, sel: sel, data: d};
    @(negedge clk_sys);
    spr_wr.en = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic acc(input logic wr, input logic stk, input acc_size_t sz, input logic [31:0] a,
    input logic [31:0] wd);
    for (int i = 0; i < 20 && exe_ready !== 1'b1; i++)
      @(negedge clk_sys);
    exe_req = '{valid: 1'b1, write: wr, stack_acc: stk, size: sz, addr: a, wdata: wd, dest: 4'h5};
    @(negedge clk_sys);
    exe_req.valid = 1'b0;
    for (int i = 0; i < 20 && addr_error !== 1'b1 && load_done !== 1'b1; i++)
    begin
      if (bus_req === 1'b1)
        seen_wd = bus_wdata;
      @(negedge clk_sys);
    end
    got_err = addr_error;
    @(negedge clk_sys);
  endtask
  task automatic t_boot;
    chk(status_word, SW_RESET);
    chk({28'h0, interrupt_mask}, 32'h0000000F);
    chk(vector_base, 32'h0);
    for (int i = 0; i < 40 && core_ready !== 1'b1; i++)
      @(negedge clk_sys);
    chk(program_counter, 32'h00000400);
    chk(stack_pointer, 32'h0000FFF0);
  endtask
  task automatic t_gprs;
    for (int i = 0; i < 16; i++)
      wr_gpr(4'(i), 32'hA0000000 | 32'(i), 1'b0);
    for (int i = 0; i < 16; i++)
    begin
      rd_a_idx = 4'(i);
      @(negedge clk_sys);
      chk(rd_a_data, 32'hA0000000 | 32'(i));
    end
    chk(index_data, 32'hA0000000);
    chk(stack_pointer, 32'hA000000F);
    rd_a_idx = 4'h9;
    wr_gpr(4'h9, 32'h12345678, 1'b1);
    chk(index_data, 32'h12345678);
    chk(index_addr, 32'hB2345681);
  endtask
  task automatic t_ctrl;
    wr_spr(spr_status, 32'hFFFFFFFF);
    chk(status_word, SW_WRITABLE);
    wr_spr(spr_status, 32'h0);
    chk({28'h0, interrupt_mask}, 32'h0);
    wr_spr(spr_gbase, 32'h00001000);
    chk(gbase_disp_addr, 32'h00001024);
    chk(gbase_index_addr, 32'h12346678);
    chk(global_base, 32'h00001000);
    wr_spr(spr_vbase, 32'h00002000);
    chk(vector_addr, 32'h0000202C);
    {link_wr_en, pc_load, mac_wr_en} = 3'h7;
    @(negedge clk_sys);
    {link_wr_en, pc_load, mac_wr_en} = 3'h0;
    spr_rd_sel = spr_link;
    @(negedge clk_sys);
    chk(spr_rd_data, 32'h00000ABC);
    chk(return_link, 32'h00000ABC);
    chk(program_counter, 32'h00000800);
    chk(mac_high, 32'h11223344);
    chk(mac_low, 32'h55667788);
  endtask
  task automatic t_stack;
    wr_gpr(4'hF, 32'h00000F00, 1'b0);
    sp_push = 1'b1;
    @(negedge clk_sys);
    {sp_push, sp_pop} = 2'h1;
    chk(stack_pointer, 32'h00000EFC);
    @(negedge clk_sys);
    sp_pop = 1'b0;
    chk(stack_pointer, 32'h00000F00);
    acc(1'b0, 1'b1, sz_word, 32'h00000F00, 32'h0);
    chk({31'h0, got_err}, 32'h1);
    acc(1'b0, 1'b1, sz_long, 32'h00000EFE, 32'h0);
    chk({31'h0, got_err}, 32'h1);
    acc(1'b1, 1'b1, sz_long, 32'h00000EFC, 32'hCAFEF00D);
    chk({31'h0, got_err}, 32'h0);
  endtask
  task automatic t_mem;
    acc_size_t sz_l[9] = '{sz_byte, sz_byte, sz_byte, sz_word, sz_word, sz_long,
      sz_word, sz_long, sz_long};
    logic [31:0] ad_l[9] = '{32'h10, 32'h13, 32'h11, 32'h12, 32'h10, 32'h10, 32'h11, 32'h12, 32'h11};
    logic [31:0] ex_l[6] = '{32'hFFFFFF80, 32'h00000001, 32'hFFFFFFFF, 32'h00007F01,
      32'hFFFF80FF, 32'h80FF7F01};
    acc(1'b1, 1'b0, sz_long, 32'h10, 32'h80FF7F01);
    chk(seen_wd, 32'h80FF7F01);
    wait_n = 2'h3;
    for (int i = 0; i < 9; i++)
    begin
      acc(1'b0, 1'b0, sz_l[i], ad_l[i], 32'h0);
      chk({31'h0, got_err}, (i < 6) ? 32'h0 : 32'h1);
      if (i < 6)
        chk(load_data, ex_l[i]);
      if (i < 6)
        chk(rd_b_data, ex_l[i]);
    end
    wait_n = 2'h0;
    acc(1'b1, 1'b0, sz_long, 32'h04000020, 32'h11223344);
    chk(seen_wd, 32'h44332211);
    acc(1'b0, 1'b0, sz_long, 32'h04000020, 32'h0);
    chk(load_data, 32'h11223344);
    acc(1'b0, 1'b0, sz_word, 32'h04000020, 32'h0);
    chk(load_data, 32'h00003344);
    chk(bus_addr, 32'h04000020);
    chk({27'h0, bus_area_two, bus_be}, 32'h0000001C);
    acc(1'b1, 1'b0, sz_byte, 32'h13, 32'h000000AB);
    chk(seen_wd, 32'hABABABAB);
    chk({27'h0, bus_write, bus_be}, 32'h00000011);
    acc(1'b0, 1'b0, sz_long, 32'h10, 32'h0);
    chk(load_data, 32'h80FF7FAB);
  endtask
  // mid-run reset: base and mask return, boot fetch repeats from base zero
  task automatic t_reboot;
    nrst = 1'b0;
    @(negedge clk_sys);
    nrst = 1'b1;
    t_boot();
  endtask
  // free-running core clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // cut a hang short
  initial
  begin
    #(5000 * 50);
    mismatches++;
    wrap_up();
  end
  // reset, then scenarios in turn
  initial
  begin
    {nrst, mac_wr_en, link_wr_en, pc_load, sp_push, sp_pop} = 6'h0;
    {rd_a_idx, rd_b_idx} = 8'h05;
    {gpr_wr, spr_wr, exe_req} = '0;
    spr_rd_sel = spr_status;
    {link_addr, pc_next, mac_result} = {32'h00000ABC, 32'h00000800, 64'h1122334455667788};
    gbase_disp = 32'h00000024;
    vec_num = 8'h0B;
    wait_n = 2'h0;
    mismatches = 0;
    n_checks = 0;
    repeat (5) @(negedge clk_sys);
    nrst = 1'b1;
    t_boot();
    t_gprs();
    t_ctrl();
    t_stack();
    t_mem();
    t_reboot();
    wrap_up();
  end
endmodule
bind cpu_regset regset_checker i_chk (
  .clk_sys(clk_sys), .nrst(nrst), .rd_a_data(rd_a_data), .index_data(index_data),
  .index_addr(index_addr), .stack_pointer(stack_pointer), .sp_push(sp_push),
  .gbase_disp(gbase_disp), .gbase_disp_addr(gbase_disp_addr), .global_base(global_base),
  .status_word(status_word), .vector_base(vector_base), .mac_high(mac_high),
  .mac_low(mac_low), .mac_wr_en(mac_wr_en), .mac_result(mac_result), .pc_load(pc_load),
  .pc_next(pc_next), .program_counter(program_counter), .core_ready(core_ready),
  .exe_req(exe_req), .exe_ready(exe_ready), .addr_error(addr_error), .bus_req(bus_req)
);
